// file: fss_forced_stop_seq.sv
// forced stop sequencer: decel ramp, brake interlock, shutoff delay, freefall lift
//
// Contract
// - stop request released: ramp speed down at configured deceleration slope
// - below zero speed during forced stop: drop brake interlock, then after shutoff delay cut base drive, engage dynamic brake
// - show forced stop warning code during whole sequence while stop request is released (not for link shutoff or alarm alone)
// - host link shutoff starts forced stop like a released request
// - no forced stop deceleration in torque control mode
// - decel disabled plus alarm: dynamic brake stop, no ramp
// - unrelated alarms need no controlled deceleration
// - after deceleration drop brake interlock, wait delay, then base shutoff
// - shutoff delay applies to stop request, alarm and link shutoff
// - delay measured from brake interlock off to base shutoff
// - freefall lift only if amount nonzero, trigger at zero speed, delay enabled
// - freefall lift commands upward displacement of configured amount before shutoff
// - zero speed flag on at threshold, off past 20 r/min hysteresis
// - deceleration enabled when function select top digit equals 2
`timescale 1ns/100ps
`default_nettype none
module fss_forced_stop_seq
   import fss_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_stop_request_input,
   input  wire logic             i_alarm,
   input  wire logic             i_alarm_unrelated,
   input  wire logic             i_link_shutoff,
   input  wire logic             i_drive_enable,
   input  wire logic [1:0]       i_control_mode,
   input  wire logic [3:0]       i_stop_function_select,
   input  wire logic [SPD_W-1:0] i_decel_time_constant,
   input  wire logic [SPD_W-1:0] i_zero_speed_threshold,
   input  wire logic [TMR_W-1:0] i_base_shutoff_delay,
   input  wire logic [POS_W-1:0] i_freefall_compensation_amount,
   input  wire logic [SPD_W-1:0] i_speed_cmd,
   input  wire logic [SPD_W-1:0] i_motor_speed,
   output logic [SPD_W-1:0]      o_speed_cmd,
   output logic                  o_brake_interlock_output,
   output logic                  o_base_drive_on,
   output logic                  o_dynamic_brake,
   output logic [POS_W-1:0]      o_lift_cmd,
   output logic                  o_lift_active,
   output logic [7:0]            o_status_code,
   output logic                  o_zero_speed_flag,
   output logic                  o_stopped
);
   // pin synchronisers, first stage read only by second
   logic [1:0] stop_sync_ff;
   logic [1:0] alarm_sync_ff;
   logic [1:0] unrel_sync_ff;
   logic [1:0] link_sync_ff;
   logic [1:0] enable_sync_ff;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         // idle level is request held, so reset never fakes a released stop
         stop_sync_ff   <= 2'h3;
         alarm_sync_ff  <= 2'h0;
         unrel_sync_ff  <= 2'h0;
         link_sync_ff   <= 2'h0;
         enable_sync_ff <= 2'h0;
      end else begin
         stop_sync_ff   <= {stop_sync_ff[0], i_stop_request_input};
         alarm_sync_ff  <= {alarm_sync_ff[0], i_alarm};
         unrel_sync_ff  <= {unrel_sync_ff[0], i_alarm_unrelated};
         link_sync_ff   <= {link_sync_ff[0], i_link_shutoff};
         enable_sync_ff <= {enable_sync_ff[0], i_drive_enable};
      end
   end
   logic stop_active;
   logic alarm_s;
   logic unrel_s;
   logic link_s;
   logic enable_s;
   assign stop_active = stop_sync_ff[1];
   assign alarm_s     = alarm_sync_ff[1];
   assign unrel_s     = unrel_sync_ff[1];
   assign link_s      = link_sync_ff[1];
   assign enable_s    = enable_sync_ff[1];

   fss_zero_if zif ();
   assign zif.speed_abs = i_motor_speed;
   assign zif.threshold = i_zero_speed_threshold;
   fss_zero_det u_zero (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .zif     (zif)
   );
   logic tick;
   logic tick_clr;
   fss_tick u_tick (
      .i_clk   (i_clk),
      .i_reset (tick_clr),
      .o_tick  (tick)
   );

   fss_state_e       state_ff;
   fss_state_e       nxt_state;
   logic [SPD_W-1:0] ramp_ff;
   logic [SPD_W-1:0] nxt_ramp;
   logic [SPD_W-1:0] step_ff;
   logic [TMR_W-1:0] delay_ff;
   logic [POS_W-1:0] lift_ff;
   logic             lift_arm_ff;
   logic             brake_il_ff;
   logic             base_on_ff;
   logic             dyn_brake_ff;
   logic [7:0]       code_ff;
   logic [SPD_W-1:0] cmd_ff;

   logic trigger;
   logic decel_en;
   logic torque_mode;
   logic direct_db;
   logic lift_ok;
   logic causes_clear;
   assign trigger      = !stop_active || alarm_s || link_s;
   // top digit of function select enables deceleration
   assign decel_en     = i_stop_function_select == FUNC_SEL_DECEL;
   assign torque_mode  = i_control_mode == MODE_TORQUE;
   // alarm with decel disabled, unrelated alarm or torque mode goes straight to dynamic brake
   assign direct_db    = (alarm_s && !decel_en) || unrel_s || torque_mode;
   // lift needs nonzero amount, zero speed trigger, nonzero delay
   assign lift_ok      = i_freefall_compensation_amount != '0 && zif.zero_speed_flag &&
                         i_base_shutoff_delay != '0;
   assign causes_clear = !trigger && !unrel_s && enable_s;
   // ramp decrement per tick from decel time constant
   assign nxt_ramp     = (ramp_ff > step_ff) ? ramp_ff - step_ff : '0;
   // divider restarts on delay entry so the delay never runs a tick short
   assign tick_clr     = i_reset || (state_ff != FSS_DELAY && nxt_state == FSS_DELAY);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         FSS_RUN: begin
            if (trigger || unrel_s) begin
               if (direct_db) nxt_state = FSS_SHUTOFF;
               else if (lift_ok) nxt_state = FSS_LIFT;
               else if (zif.zero_speed_flag) nxt_state = FSS_DELAY;
               else nxt_state = FSS_DECEL;
            end
         end
         FSS_DECEL: begin
            // zero speed reached ends the ramp
            if (unrel_s || torque_mode) nxt_state = FSS_SHUTOFF;
            else if (zif.zero_speed_flag) nxt_state = FSS_DELAY;
         end
         FSS_LIFT: nxt_state = FSS_DELAY;
         FSS_DELAY: begin
            // count from brake interlock off to base shutoff
            if (unrel_s || delay_ff == '0) nxt_state = FSS_SHUTOFF;
         end
         FSS_SHUTOFF: begin
            // hold until causes clear and drive re-enabled
            if (causes_clear) nxt_state = FSS_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) state_ff <= FSS_SHUTOFF;
      else state_ff <= nxt_state;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ramp_ff <= '0;
         step_ff <= '0;
      end else if (state_ff == FSS_RUN) begin
         ramp_ff <= i_motor_speed;
         step_ff <= (i_decel_time_constant == '0) ? i_motor_speed :
                    (i_motor_speed / i_decel_time_constant) | SPD_W'(1);
      end else if (state_ff == FSS_DECEL && tick) begin
         ramp_ff <= nxt_ramp;
      end
   end

   // delay loads when interlock drops, counts down in microseconds
   always_ff @(posedge i_clk) begin
      if (i_reset) delay_ff <= '0;
      else if (state_ff != FSS_DELAY) delay_ff <= i_base_shutoff_delay;
      else if (tick && delay_ff != '0) delay_ff <= delay_ff - TMR_W'(1);
   end

   // lift held through delay, released at shutoff
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         lift_ff     <= '0;
         lift_arm_ff <= 1'b0;
      end else if (state_ff == FSS_LIFT) begin
         lift_ff     <= i_freefall_compensation_amount;
         lift_arm_ff <= 1'b1;
      end else if (state_ff != FSS_DELAY) begin
         lift_ff     <= '0;
         lift_arm_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         brake_il_ff  <= 1'b0;
         base_on_ff   <= 1'b0;
         dyn_brake_ff <= 1'b1;
         code_ff      <= CODE_NONE;
         cmd_ff       <= '0;
      end else begin
         // interlock held through the ramp, dropped as the delay starts
         brake_il_ff  <= nxt_state == FSS_RUN || nxt_state == FSS_DECEL;
         // base drive cut and dynamic brake on at shutoff
         base_on_ff   <= nxt_state != FSS_SHUTOFF;
         dyn_brake_ff <= nxt_state == FSS_SHUTOFF;
         // warning shown while sequence runs on stop request
         code_ff      <= (nxt_state != FSS_RUN && !stop_active) ? CODE_FORCED_STOP : CODE_NONE;
         cmd_ff       <= (nxt_state == FSS_RUN) ? i_speed_cmd :
                         (nxt_state == FSS_DECEL) ? ramp_ff : '0;
      end
   end

   logic zero_q_ff;
   logic stopped_ff;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         zero_q_ff  <= 1'b1;
         stopped_ff <= 1'b1;
      end else begin
         zero_q_ff  <= zif.zero_speed_flag;
         stopped_ff <= nxt_state == FSS_SHUTOFF;
      end
   end

   assign o_speed_cmd              = cmd_ff;
   assign o_brake_interlock_output = brake_il_ff;
   assign o_base_drive_on          = base_on_ff;
   assign o_dynamic_brake          = dyn_brake_ff;
   assign o_lift_cmd               = lift_ff;
   assign o_lift_active            = lift_arm_ff;
   assign o_status_code            = code_ff;
   assign o_zero_speed_flag        = zero_q_ff;
   assign o_stopped                = stopped_ff;

   // assertions
   a_torque_no_decel: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_RUN && trigger && torque_mode) |=> state_ff == FSS_SHUTOFF)
      else $error("torque mode entered deceleration");
   a_zero_ends_decel: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_DECEL && zif.zero_speed_flag) |=> state_ff != FSS_DECEL)
      else $error("deceleration continued at zero speed");
   a_delay_interlock: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_DELAY) |-> !brake_il_ff)
      else $error("interlock on during shutoff delay");
   a_shutoff_db: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(stopped_ff) |-> dyn_brake_ff && !base_on_ff)
      else $error("shutoff without dynamic brake");
   a_hold_stopped: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_SHUTOFF && !causes_clear) |=> state_ff == FSS_SHUTOFF)
      else $error("left shutoff before causes cleared");
   a_warn_code: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_DECEL && !stop_active) |-> code_ff == CODE_FORCED_STOP)
      else $error("warning code missing in deceleration");
   a_direct_db: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_RUN && alarm_s && !decel_en) |=> state_ff == FSS_SHUTOFF)
      else $error("ramp used with deceleration disabled");
   a_lift_cond: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_LIFT) |-> i_base_shutoff_delay != '0 ##1 lift_arm_ff)
      else $error("lift without enabled delay");

   // named steps of the stop sequence
   sequence s_ramp_step;
      state_ff == FSS_DECEL && tick && ramp_ff != '0;
   endsequence
   sequence s_delay_running;
      state_ff == FSS_DELAY && delay_ff != '0 && !unrel_s;
   endsequence
   sequence s_delay_done;
      state_ff == FSS_DELAY && delay_ff == '0 && !unrel_s;
   endsequence
   sequence s_link_taken;
      state_ff == FSS_RUN && link_s && !direct_db;
   endsequence
   a_ramp_falls: assert property (@(posedge i_clk) disable iff (i_reset)
      s_ramp_step |=> ramp_ff < $past(ramp_ff))
      else $error("ramp did not fall on tick");
   a_delay_holds: assert property (@(posedge i_clk) disable iff (i_reset)
      s_delay_running |=> state_ff == FSS_DELAY)
      else $error("shutoff before delay expired");
   a_delay_cut: assert property (@(posedge i_clk) disable iff (i_reset)
      s_delay_done |=> !brake_il_ff && !base_on_ff && dyn_brake_ff)
      else $error("delay end without base shutoff");
   a_link_stop: assert property (@(posedge i_clk) disable iff (i_reset)
      s_link_taken |=> state_ff != FSS_RUN)
      else $error("link shutoff not taken");
   a_lift_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_RUN && nxt_state == FSS_LIFT) |-> zif.zero_speed_flag)
      else $error("lift started above zero speed");
   a_lift_amount: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_LIFT) |=> lift_ff == $past(i_freefall_compensation_amount))
      else $error("lift amount differs from setting");
   a_ramp_interlock: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_ff == FSS_DECEL) |-> brake_il_ff)
      else $error("interlock dropped before ramp ended");
endmodule : fss_forced_stop_seq
`default_nettype wire

// file: fss_forced_stop_seq_tb.sv
// self-checking bench for the forced stop sequencer
`timescale 1ns/100ps
`default_nettype none
module fss_forced_stop_seq_tb;
   import fss_pkg::*;
   logic        clk, rst, stop_req, alarm, alarm_unrel, link_off, drv_en;
   logic [1:0]  mode;
   logic [3:0]  func_sel;
   logic [15:0] decel_tc, zero_thr, comp_amt, spd_cmd, motor_spd, cmd_out, lift_cmd;
   logic [23:0] off_delay;
   logic        interlock, base_on, dyn_brake, lift_on, zero_flag, stopped, lift_seen, code_seen;
   logic [7:0]  status;
   logic [15:0] lift_val, mid_cmd;
   int          fail_count, checks_done, il_cycles, done_cycles, k, v;

   fss_forced_stop_seq dut (.i_clk(clk), .i_reset(rst), .i_stop_request_input(stop_req),
      .i_alarm(alarm), .i_alarm_unrelated(alarm_unrel), .i_link_shutoff(link_off),
      .i_drive_enable(drv_en), .i_control_mode(mode), .i_stop_function_select(func_sel),
      .i_decel_time_constant(decel_tc), .i_zero_speed_threshold(zero_thr),
      .i_base_shutoff_delay(off_delay), .i_freefall_compensation_amount(comp_amt),
      .i_speed_cmd(spd_cmd), .i_motor_speed(motor_spd), .o_speed_cmd(cmd_out),
      .o_brake_interlock_output(interlock), .o_base_drive_on(base_on),
      .o_dynamic_brake(dyn_brake), .o_lift_cmd(lift_cmd), .o_lift_active(lift_on),
      .o_status_code(status), .o_zero_speed_flag(zero_flag), .o_stopped(stopped));

   fss_motor_model motor (.i_clk(clk), .i_base_drive_on(base_on), .i_dynamic_brake(dyn_brake),
      .i_speed_cmd(cmd_out), .o_motor_speed(motor_spd));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // causes cleared and enable raised: the sequencer must leave its stopped state
   task automatic run_up(input logic [15:0] spd);
      int n;
      alarm = 1'b0; alarm_unrel = 1'b0; link_off = 1'b0; stop_req = 1'b1;
      spd_cmd = spd;
      drv_en = 1'b1;
      for (n = 0; n < 50 && stopped !== 1'b0; n++) @(negedge clk);
      chk(stopped, 1'b0);
      repeat (20) @(negedge clk);
   endtask : run_up

   // one toggle per run: kind 0 stop request, 1 link, 2 alarm, 3 unrelated alarm
   task automatic fire(input int kind);
      int n;
      lift_seen = 1'b0; code_seen = 1'b0; il_cycles = 0; mid_cmd = 16'h0000;
      case (kind)
         0: stop_req = 1'b0;
         1: link_off = 1'b1;
         2: alarm = 1'b1;
         default: alarm_unrel = 1'b1;
      endcase
      for (n = 0; n < 6000 && stopped !== 1'b1; n++) begin
         @(negedge clk);
         if (interlock === 1'b0) il_cycles++;
         if (n == 210) mid_cmd = cmd_out;
         if (status === CODE_FORCED_STOP) code_seen = 1'b1;
         if (lift_on === 1'b1 && !lift_seen) lift_val = lift_cmd;
         if (lift_on === 1'b1) lift_seen = 1'b1;
      end
      done_cycles = n;
      chk(base_on, 1'b0);
      chk(dyn_brake, 1'b1);
      // causes cleared but enable driven low: stopped state must hold
      stop_req = 1'b1; alarm = 1'b0; alarm_unrel = 1'b0; link_off = 1'b0; drv_en = 1'b0;
      repeat (40) @(negedge clk);
      chk(stopped, 1'b1);
   endtask : fire

   initial begin
      #400000;
      fail_count++;
      close_out();
   end

   initial begin
      v = $urandom(32'h36de2cbb);
      fail_count = 0; checks_done = 0;
      rst = 1'b1; stop_req = 1'b1; alarm = 1'b0; alarm_unrel = 1'b0; link_off = 1'b0;
      drv_en = 1'b0; mode = MODE_POSITION; func_sel = FUNC_SEL_DECEL; decel_tc = 16'h0004;
      zero_thr = ZERO_SPD_DEFAULT; off_delay = 24'h000003; comp_amt = 16'h0000;
      spd_cmd = 16'h0000;
      repeat (12) @(negedge clk);
      chk({interlock, base_on, dyn_brake, stopped, zero_flag}, 5'b00111);
      chk(status, CODE_NONE);
      rst = 1'b0;
      // zero speed hysteresis at its band edges
      run_up(16'h0000);
      for (k = 0; k < 4; k++) begin
         spd_cmd = zero_thr + ((k == 0) ? ZERO_SPD_HYST : (k == 1) ? ZERO_SPD_HYST + 16'h0001 :
                   (k == 2) ? 16'h0001 : 16'h0000);
         repeat (10) @(negedge clk);
         chk(zero_flag, (k == 0 || k == 3));
      end
      drv_en = 1'b0;
      repeat (5) @(negedge clk);
      // shutoff delay kept short for run time, like a tuned small axis
      for (k = 0; k < 3; k++) begin
         func_sel = FUNC_SEL_DECEL;
         mode = ($urandom % 2) ? MODE_SPEED : MODE_POSITION;
         decel_tc = 16'h0004 + 16'($urandom % 4);
         off_delay = 24'h000001 + 24'($urandom % 4);
         comp_amt = 16'h0001 + 16'($urandom % 255);
         run_up(16'd500 + 16'($urandom % 1500));
         fire(k);
         chk(mid_cmd < spd_cmd && mid_cmd !== 16'h0000, 1'b1);
         chk(il_cycles >= int'(off_delay) * TICK_CYCLES, 1'b1);
         chk(il_cycles <= int'(off_delay + 1) * TICK_CYCLES, 1'b1);
         chk(lift_seen, 1'b0);
         if (k == 0) chk(code_seen, 1'b1);
      end
      // direct dynamic brake stops: alarm with decel off, torque mode, unrelated alarm
      for (k = 0; k < 3; k++) begin
         func_sel = (k == 0) ? 4'h0 : FUNC_SEL_DECEL;
         mode = (k == 1) ? MODE_TORQUE : MODE_POSITION;
         run_up(16'h03e8);
         fire((k == 0) ? 2 : (k == 1) ? 0 : 3);
         chk(done_cycles < 20, 1'b1);
      end
      // freefall lift: amount zero, amount set, delay disabled
      func_sel = FUNC_SEL_DECEL;
      mode = MODE_POSITION;
      for (k = 0; k < 3; k++) begin
         comp_amt = (k == 0) ? 16'h0000 : 16'h0001 + 16'($urandom % 255);
         off_delay = (k == 2) ? 24'h000000 : 24'h000003;
         run_up(16'h0000);
         fire(0);
         chk(lift_seen, k == 1);
         if (k == 1) chk(lift_val, comp_amt);
      end
      close_out();
   end
endmodule : fss_forced_stop_seq_tb
`default_nettype wire

// file: fss_motor_model.sv
// behavioural motor and power stage driven by the sequencer outputs
`timescale 1ns/100ps
`default_nettype none
module fss_motor_model
   import fss_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_base_drive_on,
   input  wire logic             i_dynamic_brake,
   input  wire logic [SPD_W-1:0] i_speed_cmd,
   output logic [SPD_W-1:0]      o_motor_speed
);
   initial o_motor_speed = 16'h0000;
   // dynamic braking sheds speed 16 per cycle, stopping in one cycle only from 16 or less, like a real shaft
   always @(posedge i_clk) begin
      if (i_base_drive_on)
         o_motor_speed <= i_speed_cmd;
      else if (i_dynamic_brake)
         o_motor_speed <= (o_motor_speed > 16'h0010) ? o_motor_speed - 16'h0010 : 16'h0000;
   end
endmodule : fss_motor_model
`default_nettype wire

// file: fss_pkg.sv
// package for the forced stop sequencer: timing, encodings and widths
package fss_pkg;
   localparam int          CLK_FREQ_MHZ     = 200;
   // one speed/ramp tick per microsecond
   localparam int          TICK_TIME_NS     = 1000;
   localparam int          TICK_CYCLES      = (TICK_TIME_NS * CLK_FREQ_MHZ) / 1000;
   localparam int          SPD_W            = 16;
   localparam int          TMR_W            = 24;
   localparam int          POS_W            = 16;
   localparam logic [15:0] ZERO_SPD_DEFAULT = 16'h0032;
   localparam logic [15:0] ZERO_SPD_HYST    = 16'h0014;
   localparam logic [3:0]  FUNC_SEL_DECEL   = 4'h2;
   localparam logic [7:0]  CODE_NONE        = 8'h00;
   localparam logic [7:0]  CODE_FORCED_STOP = 8'he6;
   localparam logic [1:0]  MODE_POSITION    = 2'h0;
   localparam logic [1:0]  MODE_SPEED       = 2'h1;
   localparam logic [1:0]  MODE_TORQUE      = 2'h2;
   typedef enum logic [2:0] {
      FSS_RUN, FSS_DECEL, FSS_LIFT, FSS_DELAY, FSS_SHUTOFF
   } fss_state_e;
endpackage : fss_pkg

// file: fss_tick.sv
// microsecond tick generator for ramp and delay timing
`timescale 1ns/100ps
`default_nettype none
module fss_tick
   import fss_pkg::*;
#(
   parameter int DIV = TICK_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_reset,
   output logic      o_tick
);
   logic [15:0] cnt_ff;
   logic        tick_ff;
   always_ff @(posedge i_clk) begin
      if (i_reset || cnt_ff == 16'(DIV - 1)) cnt_ff <= 16'h0000;
      else cnt_ff <= cnt_ff + 16'h0001;
      tick_ff <= !i_reset && cnt_ff == 16'(DIV - 1);
   end
   assign o_tick = tick_ff;
endmodule : fss_tick
`default_nettype wire

// file: fss_zero_det.sv
// zero speed detector with hysteresis
`timescale 1ns/100ps
`default_nettype none
module fss_zero_det
   import fss_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_reset,
   fss_zero_if.det   zif
);
   logic             zero_ff;
   logic [SPD_W-1:0] off_level;
   logic             nxt_zero;
   assign off_level = zif.threshold + ZERO_SPD_HYST;
   // on at threshold, off above threshold plus band
   assign nxt_zero = zero_ff ? (zif.speed_abs <= off_level) : (zif.speed_abs <= zif.threshold);
   always_ff @(posedge i_clk) begin
      if (i_reset) zero_ff <= 1'b1;
      else zero_ff <= nxt_zero;
   end
   assign zif.zero_speed_flag = zero_ff;
endmodule : fss_zero_det
`default_nettype wire

// file: fss_zero_if.sv
// interface carrying speed and zero speed flag between sequencer and detector
`timescale 1ns/100ps
`default_nettype none
interface fss_zero_if;
   import fss_pkg::*;
   logic [SPD_W-1:0] speed_abs;
   logic [SPD_W-1:0] threshold;
   logic             zero_speed_flag;
   modport det (input speed_abs, input threshold, output zero_speed_flag);
   modport seq (output speed_abs, output threshold, input zero_speed_flag);
endinterface : fss_zero_if
`default_nettype wire
